// file: bench/adc_sequencer_control_panel_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_control_panel_tb import adc_ctl_pkg::*;;
    logic mclk, arst_n, csN, rdN, wrN, instrBusy, cmpStart, windowCmp, convActive, convValid, syncIn;
    logic [3:0] regAddr;
    logic [15:0] dataIn, dataOut_q, fifoWord_q;
    logic [2:0] instrPtr, convPtr, chanCode;
    logic [8:0] sampleVal;
    logic [12:0] convData;
    logic dataOe_q, syncOut_q, syncOe_q, syncStart_q, seqRun_q, seqHold_q, seqReset_q, clkEnable_q;
    logic analogPowerDown_q, autoZeroEach_q, fifoWordValid_q, limitHit1_q, limitHit2_q;
    logic shortCalDone_q, fullCalDone_q, standbyDone_q, ok;
    logic [1:0] diagRoute_q;
    logic [7:0] ev;
    logic [15:0] v;
    logic [15:0] tSect [3] = '{16'h0100, 16'h0200, 16'h0300};
    logic [15:0] tData [3] = '{16'hFFFF, 16'h0105, 16'h0000};
    logic [15:0] tExp [3] = '{16'h03FF, 16'h0105, 16'h0000};
    logic [1:0] tRoute [3] = '{ROUTE_REFOUT_GND, ROUTE_REFP_REFN, ROUTE_NORMAL};
    int error_cnt = 0;
    int checks = 0;

    assign ev = {~seqRun_q, ~clkEnable_q, fifoWordValid_q, limitHit2_q, limitHit1_q,
                 standbyDone_q, fullCalDone_q, shortCalDone_q};

    // shortened full calibration and settle counts keep the run brief
    adc_sequencer_control_panel #(.FULL_CAL_CYC(40), .SETTLE_CYC(20)) dut_u (
        .mclk(mclk), .arst_n(arst_n), .csN(csN), .rdN(rdN), .wrN(wrN), .regAddr(regAddr),
        .dataIn(dataIn), .dataOut_q(dataOut_q), .dataOe_q(dataOe_q), .instrBusy(instrBusy),
        .instrPtr(instrPtr), .cmpStart(cmpStart), .windowCmp(windowCmp), .sampleVal(sampleVal),
        .convActive(convActive), .convValid(convValid), .convData(convData), .convPtr(convPtr),
        .chanCode(chanCode), .syncIn(syncIn), .syncOut_q(syncOut_q), .syncOe_q(syncOe_q),
        .syncStart_q(syncStart_q), .seqRun_q(seqRun_q), .seqHold_q(seqHold_q),
        .seqReset_q(seqReset_q), .clkEnable_q(clkEnable_q),
        .analogPowerDown_q(analogPowerDown_q), .autoZeroEach_q(autoZeroEach_q),
        .fifoWord_q(fifoWord_q), .fifoWordValid_q(fifoWordValid_q), .limitHit1_q(limitHit1_q),
        .limitHit2_q(limitHit2_q), .shortCalDone_q(shortCalDone_q),
        .fullCalDone_q(fullCalDone_q), .standbyDone_q(standbyDone_q), .diagRoute_q(diagRoute_q));

    host_bus_model host_u (.mclk(mclk), .csN(csN), .rdN(rdN), .wrN(wrN), .regAddr(regAddr),
        .dataIn(dataIn), .dataOut_q(dataOut_q));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic complete_run();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // event k must first show between lo and hi+1 edges from now
    task automatic wait_ev(input int k, input int lo, input int hi);
        int n;
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit && n <= hi) begin
            @(posedge mclk);
            n++;
            hit = (ev[k] === 1'b1);
        end
        chk({15'h0000, hit && n >= lo}, 16'h0001);
    endtask

    task automatic conv(input logic [15:0] exp);
        @(posedge mclk);
        convValid <= 1'b1;
        @(posedge mclk);
        convValid <= 1'b0;
        wait_ev(5, 0, 3);
        chk(fifoWord_q, exp);
    endtask

    task automatic compare(input logic [8:0] s, input int k, input int lo, input int hi);
        @(posedge mclk);
        sampleVal <= s;
        cmpStart <= 1'b1;
        @(posedge mclk);
        cmpStart <= 1'b0;
        wait_ev(k, lo, hi);
    endtask

    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end

    initial begin
        arst_n <= 1'b0;
        {instrBusy, cmpStart, convActive, convValid, syncIn} <= 5'h00;
        windowCmp <= 1'b1;
        instrPtr <= 3'h3;
        convPtr <= 3'h5;
        chanCode <= 3'h0;
        sampleVal <= 9'h000;
        convData <= 13'h1ABC;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        host_u.wait_ready(ok);
        chk({15'h0000, ok}, 16'h0001);
        host_u.rd(CFG_ADDR, v);
        chk(v, 16'h0000);
        host_u.wr(CFG_ADDR, 16'h00E1);
        host_u.rd(CFG_ADDR, v);
        chk(v, 16'h00E1);
        chk({14'h0000, autoZeroEach_q, syncOe_q}, 16'h0003);
        convActive <= 1'b1;
        repeat (3) @(posedge mclk);
        chk({15'h0000, syncOut_q}, 16'h0001);
        convActive <= 1'b0;
        conv(16'hFABC);
        host_u.wr(CFG_ADDR, 16'h00C1);
        conv(16'hBABC);
        instrBusy <= 1'b1;
        host_u.wr(CFG_ADDR, 16'h00C0);
        repeat (3) @(posedge mclk);
        chk({15'h0000, seqRun_q}, 16'h0001);
        instrBusy <= 1'b0;
        wait_ev(7, 0, 4);
        instrBusy <= 1'b1;
        host_u.wr(CFG_ADDR, 16'h00C4);
        repeat (90) @(posedge mclk);
        instrBusy <= 1'b0;
        wait_ev(0, 76, 84);
        host_u.rd(CFG_ADDR, v);
        chk(v, 16'h00C0);
        host_u.wr(CFG_ADDR, 16'h00C8);
        wait_ev(1, 40, 46);
        host_u.rd(CFG_ADDR, v);
        chk(v, 16'h00C0);
        for (int i = 0; i < 3; i++) begin
            host_u.wr(CFG_ADDR, tSect[i]);
            host_u.wr(4'h3, tData[i]);
            host_u.rd(4'h3, v);
            chk(v, tExp[i]);
        end
        host_u.wr(CFG_ADDR, 16'h0200);
        host_u.rd(4'h3, v);
        chk(v, 16'h0105);
        host_u.rd(4'h9, v);
        chk(v, 16'h0000);
        chk({15'h0000, dataOe_q}, 16'h0001);
        host_u.wr(CFG_ADDR, 16'h0100);
        host_u.wr(4'h3, 16'h0205);
        compare(9'h00A, 3, 1, 3);
        compare(9'h10A, 4, 2, 4);
        host_u.wr(CFG_ADDR, 16'h0C00);
        for (int c = 0; c < 3; c++) begin
            chanCode <= c[2:0];
            repeat (3) @(posedge mclk);
            chk({14'h0000, diagRoute_q}, {14'h0000, tRoute[c]});
        end
        syncIn <= 1'b1;
        repeat (2) @(posedge mclk);
        chk({15'h0000, syncStart_q}, 16'h0001);
        @(posedge mclk);
        chk({15'h0000, syncStart_q}, 16'h0000);
        syncIn <= 1'b0;
        host_u.wr(CFG_ADDR, 16'h0001);
        repeat (3) @(posedge mclk);
        chk({15'h0000, seqRun_q}, 16'h0001);
        host_u.wr(CFG_ADDR, 16'h0003);
        wait_ev(7, 0, 4);
        chk({14'h0000, seqReset_q, seqHold_q}, 16'h0003);
        host_u.wait_ready(ok);
        chk({15'h0000, ok}, 16'h0001);
        host_u.wr(CFG_ADDR, 16'h0108);
        host_u.wr(CFG_ADDR, 16'h0110);
        wait_ev(6, 0, 3);
        chk({15'h0000, analogPowerDown_q}, 16'h0001);
        host_u.rd(4'h3, v);
        chk(v, 16'h0205);
        host_u.wr(CFG_ADDR, 16'h0100);
        wait_ev(2, 15, 26);
        host_u.wait_ready(ok);
        chk({15'h0000, ok}, 16'h0001);
        host_u.rd(CFG_ADDR, v);
        chk(v, 16'h0100);
        complete_run();
    end
endmodule
`default_nettype wire

// file: bench/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model import adc_ctl_pkg::*; (
    input wire logic mclk,
    output logic csN,
    output logic rdN,
    output logic wrN,
    output logic [3:0] regAddr,
    output logic [15:0] dataIn,
    input wire logic [15:0] dataOut_q
);
    initial begin
        csN <= 1'b1;
        rdN <= 1'b1;
        wrN <= 1'b1;
        regAddr <= 4'h0;
        dataIn <= 16'h0000;
    end

    // strobe drops once and rises at the taking edge, so every write gets a high gap
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        csN <= 1'b0;
        wrN <= 1'b0;
        regAddr <= a;
        dataIn <= (a == CFG_ADDR) ? {d[15:11], 1'b0, d[9:0]} : d;
        @(posedge mclk);
        csN <= 1'b1;
        wrN <= 1'b1;
        dataIn <= ~d;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        csN <= 1'b0;
        rdN <= 1'b0;
        regAddr <= a;
        @(posedge mclk);
        @(posedge mclk);
        d = dataOut_q;
        csN <= 1'b1;
        rdN <= 1'b1;
    endtask

    // nothing else is started until the reset bit reads back low or 20 reads have passed
    task automatic wait_ready(output logic ok);
        logic [15:0] v;
        ok = 1'b0;
        for (int n = 0; n < 20 && !ok; n++) begin
            rd(CFG_ADDR, v);
            ok = (v[BIT_RST] === 1'b0);
        end
    endtask
endmodule
`default_nettype wire

// file: rtl/adc_ctl_pkg.sv
package adc_ctl_pkg;
    localparam logic [3:0] CFG_ADDR = 4'h8;
    localparam int RAM_DEPTH = 8;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam int BIT_RUN = 0;
    localparam int BIT_RST = 1;
    localparam int BIT_AZ = 2;
    localparam int BIT_FCAL = 3;
    localparam int BIT_STBY = 4;
    localparam int BIT_MASK = 5;
    localparam int BIT_AZEACH = 6;
    localparam int BIT_SYNCOUT = 7;
    localparam int BIT_SECT = 8;
    localparam int BIT_TEST = 10;
    localparam int BIT_DIAG = 11;
    localparam logic [1:0] SECT_CODE = 2'h0;
    localparam logic [1:0] SECT_LIM1 = 2'h1;
    localparam logic [1:0] SECT_LIM2 = 2'h2;
    localparam int LIM_SIGN_BIT = 8;
    localparam int LIM_ABOVE_BIT = 9;
    localparam int LIM_WIDTH = 10;
    localparam int CONV_SIGN_BIT = 12;
    localparam int TAG_LSB = 13;
    localparam logic [2:0] DIAG_CH_REFOUT = 3'h0;
    localparam logic [2:0] DIAG_CH_REFS = 3'h1;
    localparam logic [1:0] ROUTE_NORMAL = 2'h0;
    localparam logic [1:0] ROUTE_REFOUT_GND = 2'h1;
    localparam logic [1:0] ROUTE_REFP_REFN = 2'h2;
    localparam logic [1:0] RESET_HOLD_CYCLES = 2'h2;
    localparam int SHORT_CAL_CYCLES = 76;
    localparam int FULL_CAL_CYCLES = 4944;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SETTLE_TIME_MS = 10;
    localparam int SETTLE_CYCLES = SETTLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
endpackage

// file: rtl/adc_sequencer_control_panel.sv
// Function
// - section selector picks instruction third accessed
// - limit one magnitude bits 0-7, sign 8
// - window compare: limit one, then limit two
// - limit one bit 9 selects above/below
// - limit two magnitude, sign, above/below bits
// - control register is 16-bit read/write
// - run bit reads back running status
// - run 0 stops after instruction; 1 resumes
// - reset bit stops, clears pointer, FIFO, flags
// - reset self-clears after two clocks unless standby
// - short auto-zero request deferred while instruction runs
// - short auto-zero 76 cycles, self-clears, flags
// - full calibration request deferred while instruction runs
// - full calibration 4944 cycles, self-clears, flags
// - standby gates clock, RAM stays accessible
// - leaving standby resets, then settle interrupt
// - channel mask selects sign copy or pointer tag
// - bit 6 inserts auto-zero before each conversion
// - bit 7 sets sync pin direction and behaviour
// - diagnostic only while test bit is zero
// - diagnostic routes channels 000 and 001 specially
// - standby completion after 10 ms settle delay
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_control_panel import adc_ctl_pkg::*; #(
    parameter int FULL_CAL_CYC = FULL_CAL_CYCLES,
    parameter int SETTLE_CYC = SETTLE_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic csN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] dataIn,
    output logic [15:0] dataOut_q,
    output logic dataOe_q,
    input wire logic instrBusy,
    input wire logic [2:0] instrPtr,
    input wire logic cmpStart,
    input wire logic windowCmp,
    input wire logic [8:0] sampleVal,
    input wire logic convActive,
    input wire logic convValid,
    input wire logic [12:0] convData,
    input wire logic [2:0] convPtr,
    input wire logic [2:0] chanCode,
    input wire logic syncIn,
    output logic syncOut_q,
    output logic syncOe_q,
    output logic syncStart_q,
    output logic seqRun_q,
    output logic seqHold_q,
    output logic seqReset_q,
    output logic clkEnable_q,
    output logic analogPowerDown_q,
    output logic autoZeroEach_q,
    output logic [15:0] fifoWord_q,
    output logic fifoWordValid_q,
    output logic limitHit1_q,
    output logic limitHit2_q,
    output logic shortCalDone_q,
    output logic fullCalDone_q,
    output logic standbyDone_q,
    output logic [1:0] diagRoute_q
);
    typedef enum logic [1:0] {CMP_IDLE, CMP_ONE, CMP_TWO} cmp_e;
    localparam int SW = $clog2(SETTLE_CYC + 1);

    function automatic logic limitCrossed(input logic [8:0] smp, input logic [9:0] lim);
        logic signed [9:0] s;
        logic signed [9:0] l;
        s = smp[LIM_SIGN_BIT] ? -$signed({2'b00, smp[7:0]}) : $signed({2'b00, smp[7:0]});
        l = lim[LIM_SIGN_BIT] ? -$signed({2'b00, lim[7:0]}) : $signed({2'b00, lim[7:0]});
        return lim[LIM_ABOVE_BIT] ? (s > l) : (s < l);
    endfunction

    logic [LIM_WIDTH-1:0] limOne [RAM_DEPTH];
    logic [LIM_WIDTH-1:0] limTwo [RAM_DEPTH];
    logic [11:5] cfgHi_q;
    logic running_q, stopReq_q, standby_q, azReq_q, fullReq_q;
    logic [1:0] rstCnt_q;
    logic wrPrev_q, syncPrev_q, calStart_q, calFull_q;
    logic [SW-1:0] settleCnt_q;
    cmp_e cmp_q;
    logic [8:0] cmpSample_q;
    logic [2:0] cmpPtr_q;

    cal_if calBus();
    cal_timer #(.SHORT_CYC(SHORT_CAL_CYCLES), .FULL_CYC(FULL_CAL_CYC)) u_cal_timer (
        .mclk(mclk),
        .arst_n(arst_n),
        .cal(calBus.timer)
    );

    // strobes are sampled as synchronous levels; acting on the leading edge keeps
    // a long write strobe from retriggering the reset count
    wire logic wrAct = !csN && !wrN;
    wire logic rdAct = !csN && !rdN;
    wire logic wrStrobe = wrAct && !wrPrev_q;
    wire logic cfgWr = wrStrobe && regAddr == CFG_ADDR;
    wire logic ramSel = !regAddr[3];
    wire logic [2:0] ramIdx = regAddr[2:0];
    wire logic [1:0] sect = cfgHi_q[BIT_SECT+1:BIT_SECT];
    wire logic limOneWr = wrStrobe && ramSel && sect == SECT_LIM1;
    wire logic limTwoWr = wrStrobe && ramSel && sect == SECT_LIM2;
    wire logic resetBit = rstCnt_q != 2'h0 || standby_q;
    wire logic stbyExit = cfgWr && standby_q && !dataIn[BIT_STBY];
    wire logic rstTrig = (cfgWr && dataIn[BIT_RST]) || stbyExit;
    wire logic calReady = (azReq_q || fullReq_q) && !calBus.busy && !calBus.done
        && !calStart_q && !instrBusy && !resetBit;
    wire logic calDoneShort = calBus.done && !calFull_q;
    wire logic calDoneFull = calBus.done && calFull_q;
    wire logic syncOutMode = cfgHi_q[BIT_SYNCOUT];
    wire logic diagOn = cfgHi_q[BIT_DIAG] && !cfgHi_q[BIT_TEST];
    wire logic [15:0] cfgRead = {4'h0, cfgHi_q, standby_q, fullReq_q, azReq_q,
        resetBit, running_q};
    wire logic [15:0] ramRead = sect == SECT_LIM1 ? {6'h00, limOne[ramIdx]} :
        sect == SECT_LIM2 ? {6'h00, limTwo[ramIdx]} : 16'h0000;
    wire logic [15:0] readVal = regAddr == CFG_ADDR ? cfgRead : ramSel ? ramRead : 16'h0000;
    wire logic [1:0] routeSel = !diagOn ? ROUTE_NORMAL :
        chanCode == DIAG_CH_REFOUT ? ROUTE_REFOUT_GND :
        chanCode == DIAG_CH_REFS ? ROUTE_REFP_REFN : ROUTE_NORMAL;
    wire logic hitOne = limitCrossed(cmpSample_q, limOne[cmpPtr_q]);
    wire logic hitTwo = limitCrossed(cmpSample_q, limTwo[cmpPtr_q]);

    assign calBus.start = calStart_q;
    assign calBus.full = calFull_q;
    // standby only freezes a running calibration; the reset count on leaving standby aborts it
    assign calBus.clear = rstCnt_q != 2'h0;
    assign calBus.enable = !standby_q;

    // limit words live outside the reset so they survive standby and soft reset
    always_ff @(posedge mclk) begin
        if (limOneWr) begin
            limOne[ramIdx] <= dataIn[LIM_WIDTH-1:0];
        end
        if (limTwoWr) begin
            limTwo[ramIdx] <= dataIn[LIM_WIDTH-1:0];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cfgHi_q <= CFG_RESET[11:5];
            standby_q <= 1'b0;
            wrPrev_q <= 1'b0;
            dataOut_q <= 16'h0000;
            dataOe_q <= 1'b0;
        end else begin
            wrPrev_q <= wrAct;
            dataOut_q <= rdAct ? readVal : 16'h0000;
            dataOe_q <= rdAct;
            if (cfgWr) begin
                cfgHi_q <= dataIn[11:5];
                standby_q <= dataIn[BIT_STBY];
            end
        end
    end

    // a power-on reset loads the count, so the reset bit reads 1 for two cycles
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rstCnt_q <= RESET_HOLD_CYCLES;
            running_q <= 1'b0;
            stopReq_q <= 1'b0;
        end else begin
            if (rstTrig) begin
                rstCnt_q <= RESET_HOLD_CYCLES;
            end else if (rstCnt_q != 2'h0) begin
                rstCnt_q <= rstCnt_q - 2'h1;
            end
            if (resetBit || rstTrig) begin
                running_q <= 1'b0;
                stopReq_q <= 1'b0;
            end else if (cfgWr && dataIn[BIT_RUN]) begin
                running_q <= 1'b1;
                stopReq_q <= 1'b0;
            end else if (cfgWr) begin
                stopReq_q <= running_q;
            end else if (stopReq_q && !instrBusy) begin
                running_q <= 1'b0;
                stopReq_q <= 1'b0;
            end
        end
    end

    // a host write of 1 in the cycle of completion wins over the self-clear
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            azReq_q <= 1'b0;
            fullReq_q <= 1'b0;
            calStart_q <= 1'b0;
            calFull_q <= 1'b0;
            shortCalDone_q <= 1'b0;
            fullCalDone_q <= 1'b0;
        end else begin
            calStart_q <= calReady;
            if (calReady) begin
                calFull_q <= !azReq_q;
            end
            shortCalDone_q <= calDoneShort;
            fullCalDone_q <= calDoneFull;
            if (resetBit) begin
                azReq_q <= 1'b0;
                fullReq_q <= 1'b0;
            end else begin
                azReq_q <= (cfgWr && dataIn[BIT_AZ]) || (azReq_q && !calDoneShort);
                fullReq_q <= (cfgWr && dataIn[BIT_FCAL]) || (fullReq_q && !calDoneFull);
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            settleCnt_q <= '0;
            standbyDone_q <= 1'b0;
        end else begin
            standbyDone_q <= settleCnt_q == SW'(1) && !standby_q;
            if (stbyExit) begin
                settleCnt_q <= SW'(SETTLE_CYC);
            end else if (standby_q) begin
                settleCnt_q <= '0;
            end else if (settleCnt_q != '0) begin
                settleCnt_q <= settleCnt_q - 1'b1;
            end
        end
    end

    // both limits are checked against one held sample, one after the other
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cmp_q <= CMP_IDLE;
            cmpSample_q <= 9'h000;
            cmpPtr_q <= 3'h0;
            limitHit1_q <= 1'b0;
            limitHit2_q <= 1'b0;
        end else begin
            limitHit1_q <= cmp_q == CMP_ONE && hitOne;
            limitHit2_q <= cmp_q == CMP_TWO && hitTwo;
            unique case (cmp_q)
                CMP_IDLE: begin
                    if (cmpStart && windowCmp && clkEnable_q) begin
                        cmp_q <= CMP_ONE;
                        cmpSample_q <= sampleVal;
                        cmpPtr_q <= instrPtr;
                    end
                end
                CMP_ONE: cmp_q <= CMP_TWO;
                CMP_TWO: cmp_q <= CMP_IDLE;
                default: cmp_q <= CMP_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            seqRun_q <= 1'b0;
            seqHold_q <= 1'b1;
            seqReset_q <= 1'b1;
            clkEnable_q <= 1'b1;
            analogPowerDown_q <= 1'b0;
            autoZeroEach_q <= 1'b0;
            syncPrev_q <= 1'b0;
            syncOut_q <= 1'b0;
            syncOe_q <= 1'b0;
            syncStart_q <= 1'b0;
            fifoWord_q <= 16'h0000;
            fifoWordValid_q <= 1'b0;
            diagRoute_q <= ROUTE_NORMAL;
        end else begin
            seqRun_q <= running_q;
            seqHold_q <= calBus.busy || calStart_q || resetBit;
            seqReset_q <= resetBit;
            clkEnable_q <= !standby_q;
            analogPowerDown_q <= standby_q;
            autoZeroEach_q <= cfgHi_q[BIT_AZEACH];
            syncPrev_q <= syncIn;
            syncOut_q <= syncOutMode && convActive;
            syncOe_q <= syncOutMode;
            syncStart_q <= !syncOutMode && syncIn && !syncPrev_q && !standby_q;
            fifoWord_q <= {cfgHi_q[BIT_MASK] ? {3{convData[CONV_SIGN_BIT]}} : convPtr,
                convData};
            fifoWordValid_q <= convValid;
            diagRoute_q <= routeSel;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    property p_sect_write;
        limOneWr |=> limOne[$past(ramIdx)] == $past(dataIn[9:0]);
    endproperty
    a_sect_write: assert property (p_sect_write) else $error("limit one write lost");
    property p_lim_read;
        rdAct && ramSel && sect == SECT_LIM2 |=> dataOut_q[15:10] == 6'h00 && dataOe_q;
    endproperty
    a_lim_read: assert property (p_lim_read) else $error("limit two read malformed");
    property p_two_compares;
        cmp_q == CMP_IDLE && cmpStart && windowCmp && clkEnable_q |=> cmp_q == CMP_ONE
            ##1 cmp_q == CMP_TWO ##1 cmp_q == CMP_IDLE;
    endproperty
    a_two_compares: assert property (p_two_compares) else $error("compare order wrong");
    property p_hit_one;
        cmp_q == CMP_ONE && hitOne |=> limitHit1_q;
    endproperty
    a_hit_one: assert property (p_hit_one) else $error("limit one hit missed");
    property p_run_read;
        rdAct && regAddr == CFG_ADDR |=> dataOut_q[BIT_RUN] == $past(running_q);
    endproperty
    a_run_read: assert property (p_run_read) else $error("run status read wrong");
    property p_reset_len;
        cfgWr && dataIn[BIT_RST] && !dataIn[BIT_STBY] ##1 !wrStrobe[*2]
            |-> $past(resetBit) && resetBit ##1 !resetBit;
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset bit length wrong");
    property p_reset_stops;
        rstTrig |=> !running_q ##1 seqReset_q && !seqRun_q;
    endproperty
    a_reset_stops: assert property (p_reset_stops) else $error("reset did not stop");
    property p_cal_defer;
        calStart_q |-> $past(!instrBusy) && $past(azReq_q || fullReq_q);
    endproperty
    a_cal_defer: assert property (p_cal_defer) else $error("calibration started early");
    property p_gate;
        standby_q |=> !clkEnable_q && analogPowerDown_q;
    endproperty
    a_gate: assert property (p_gate) else $error("standby did not gate clock");
    property p_mask;
        cfgHi_q[BIT_MASK] |=> fifoWord_q[15:13] == {3{$past(convData[CONV_SIGN_BIT])}};
    endproperty
    a_mask: assert property (p_mask) else $error("mask did not copy sign");
    property p_settle;
        settleCnt_q == SW'(1) && !standby_q |=> standbyDone_q;
    endproperty
    a_settle: assert property (p_settle) else $error("standby completion missed");
    property p_diag;
        diagRoute_q != ROUTE_NORMAL |-> $past(cfgHi_q[BIT_DIAG] && !cfgHi_q[BIT_TEST]);
    endproperty
    a_diag: assert property (p_diag) else $error("diagnostic routing while test set");

    c_short_done: cover property (shortCalDone_q);
    c_full_done: cover property (fullCalDone_q);
    c_limit_two: cover property (limitHit2_q);
    c_standby_done: cover property (standbyDone_q);
endmodule
`default_nettype wire

// file: rtl/cal_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cal_if;
    logic start;
    logic full;
    logic clear;
    logic enable;
    logic busy;
    logic done;
    modport ctrl(output start, output full, output clear, output enable, input busy, input done);
    modport timer(input start, input full, input clear, input enable, output busy, output done);
endinterface
`default_nettype wire

// file: rtl/cal_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cal_timer import adc_ctl_pkg::*; #(
    parameter int SHORT_CYC = SHORT_CAL_CYCLES,
    parameter int FULL_CYC = FULL_CAL_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    cal_if.timer cal
);
    // sized for the longer of the two runs, so a short full count cannot truncate the short one
    localparam int CW = $clog2((FULL_CYC > SHORT_CYC ? FULL_CYC : SHORT_CYC) + 1);
    logic [CW-1:0] cnt_q;
    logic busy_q;
    logic done_q;
    wire logic [CW-1:0] loadVal = cal.full ? CW'(FULL_CYC - 1) : CW'(SHORT_CYC - 1);

    // the count freezes while the clock is gated off; leaving standby is a reset, which aborts it
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (cal.clear) begin
                busy_q <= 1'b0;
            end else if (cal.start) begin
                busy_q <= 1'b1;
                cnt_q <= loadVal;
            end else if (busy_q && cal.enable) begin
                if (cnt_q == '0) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end
    assign cal.busy = busy_q;
    assign cal.done = done_q;

    property p_short_load;
        @(posedge mclk) disable iff (!arst_n)
        cal.start && !cal.clear && !cal.full |=> busy_q && cnt_q == CW'(SHORT_CYC - 1);
    endproperty
    a_short_load: assert property (p_short_load) else $error("short calibration length wrong");
    property p_full_load;
        @(posedge mclk) disable iff (!arst_n)
        cal.start && !cal.clear && cal.full |=> busy_q && cnt_q == CW'(FULL_CYC - 1);
    endproperty
    a_full_load: assert property (p_full_load) else $error("full calibration length wrong");
    property p_finish;
        @(posedge mclk) disable iff (!arst_n)
        busy_q && cal.enable && !cal.clear && !cal.start && cnt_q == '0 |=> done_q && !busy_q;
    endproperty
    a_finish: assert property (p_finish) else $error("calibration did not finish at zero");
    property p_hold;
        @(posedge mclk) disable iff (!arst_n)
        busy_q && !cal.enable && !cal.clear && !cal.start |=> cnt_q == $past(cnt_q) && busy_q;
    endproperty
    a_hold: assert property (p_hold) else $error("calibration ran while clock gated");
endmodule
`default_nettype wire
